// ==== elr_pkg.sv ====
// Constants for the extended log read engine: command code, log map,
// sector layouts, control register map and timing.
// Assumes a single 25 MHz drive clock.
package elr_pkg;
    // Command and log addresses
    localparam logic [7:0] ELR_CMD_READ_LOG = 8'h2f;
    localparam logic [7:0] ELR_LOG_DIR      = 8'h00;
    localparam logic [7:0] ELR_LOG_ERR      = 8'h03;
    localparam logic [7:0] ELR_LOG_OLD_ST   = 8'h06;
    localparam logic [7:0] ELR_LOG_ST       = 8'h07;
    localparam logic [7:0] ELR_LOG_HOST_LO  = 8'h80;
    localparam logic [7:0] ELR_LOG_HOST_HI  = 8'h9f;
    localparam logic [16:0] ELR_SECS_ONE    = 17'h00001;
    localparam logic [16:0] ELR_SECS_HOST   = 17'h00010;
    // Sector layout
    localparam logic [8:0] ELR_OFF_LAST     = 9'h1ff;
    localparam logic [8:0] ELR_OFF_ENTRY    = 9'h004;
    localparam logic [8:0] ELR_OFF_ECNT     = 9'h1f4;
    localparam logic [8:0] ELR_OFF_IDX      = 9'h002;
    localparam logic [7:0] ELR_DIR_VERSION  = 8'h01;
    localparam logic [7:0] ELR_ERR_VERSION  = 8'h01;
    localparam logic [7:0] ELR_ST_REVISION  = 8'h01;
    localparam int ELR_ERR_ENTRIES          = 4;
    localparam int ELR_ERR_ENTRY_BYTES      = 124;
    localparam int ELR_CMD_SNAP_BYTES       = 18;
    localparam int ELR_CMD_SNAPS            = 5;
    localparam int ELR_ERR_SNAP_BYTES       = 34;
    localparam int ELR_ST_ENTRIES           = 18;
    localparam int ELR_ST_ENTRY_BYTES       = 26;
    localparam logic [6:0] ELR_ERR_LAST_O   = 7'd123;
    localparam logic [6:0] ELR_ST_LAST_O    = 7'd25;
    // Power/activity state codes captured into the error snapshot
    localparam logic [2:0] ELR_PS_UNKNOWN   = 3'h0;
    localparam logic [2:0] ELR_PS_SLEEP     = 3'h1;
    localparam logic [2:0] ELR_PS_STANDBY   = 3'h2;
    localparam logic [2:0] ELR_PS_ACTIVE    = 3'h3;
    localparam logic [2:0] ELR_PS_SELFTEST  = 3'h4;
    // Control register map (byte addresses)
    localparam logic [3:0] ELR_REG_CTRL     = 4'h0;
    localparam logic [3:0] ELR_REG_STAT     = 4'h4;
    localparam logic [3:0] ELR_REG_ECNT     = 4'h8;
    localparam logic [2:0] ELR_CTRL_RESET   = 3'h7;
    localparam int ELR_CTRL_SMART           = 0;
    localparam int ELR_CTRL_ERRLOG          = 1;
    localparam int ELR_CTRL_SELFTEST        = 2;
    // Timing
    localparam int ELR_CLK_NS               = 40;
    localparam int ELR_MS_NS                = 1000000;
    localparam int ELR_CYC_PER_MS           = ELR_MS_NS / ELR_CLK_NS;
    // Transfer states
    typedef enum logic [2:0] {
        ELR_IDLE = 3'b001,
        ELR_XFER = 3'b010,
        ELR_DRAIN = 3'b100
    } elr_state_t;
endpackage

// ==== elr_engine.sv ====
// Extended log read engine: decodes the log read command, streams log
// sectors byte by byte, and keeps the error and self-test histories.
// Assumes synchronous task-file inputs and a host that drains the byte stream.
//
// Functional notes
// - Count is previous-sector-number:current-sector-count
// - Data starts at requested sector offset
// - Sector number selects log; start from cylinder-low
// - Log map: directory, error, self-test, host
// - Log address 06h always aborts
// - Abort unsupported, disabled or invalid requests
// - Directory version word is 0001h
// - Per-log sector counts; host logs 16
// - Error sector: version, index, entries, count
// - Error index names newest entry, 0-4
// - Four error entries circular; unused zero
// - Host-caused errors never logged or counted
// - Device error count saturates, never wraps
// - Entry: five command snapshots, error snapshot
// - Command snapshot fields and millisecond timestamp
// - Snapshot high byte holds prior write
// - Error snapshot fields, state, hour stamp
// - Error snapshot low/high by readback bit
// - State captured when failing command arrived
// - Self-test sector: revision, index, descriptors
// - Eighteen descriptors circular; unused zero
// - Self-test log holds 28-bit and 48-bit entries
// - Command 2Fh is the log read
// - Interrupt for every sector block sent
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
module elr_engine
    import elr_pkg::*;
#(
    parameter int CYC_PER_MS = ELR_CYC_PER_MS
) (
    // Clock, reset, enable
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        en_i,
    // Register port
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    // Task-file snapshot at command issue
    input  wire logic        cmd_valid_i,
    input  wire logic [7:0]  cmd_code_i,
    input  wire logic [7:0]  devctl_i,
    input  wire logic [7:0]  feat_cur_i,
    input  wire logic [7:0]  feat_prev_i,
    input  wire logic [7:0]  sc_cur_i,
    input  wire logic [7:0]  sc_prev_i,
    input  wire logic [7:0]  sn_cur_i,
    input  wire logic [7:0]  sn_prev_i,
    input  wire logic [7:0]  cl_cur_i,
    input  wire logic [7:0]  cl_prev_i,
    input  wire logic [7:0]  ch_cur_i,
    input  wire logic [7:0]  ch_prev_i,
    input  wire logic [7:0]  devhead_i,
    input  wire logic [2:0]  pwr_state_i,
    // Error report, result fields as {readback hob=1, hob=0}
    input  wire logic        err_log_i,
    input  wire logic        err_dev_i,
    input  wire logic [7:0]  err_code_i,
    input  wire logic [15:0] err_sc_i,
    input  wire logic [15:0] err_sn_i,
    input  wire logic [15:0] err_cl_i,
    input  wire logic [15:0] err_ch_i,
    input  wire logic [7:0]  err_dh_i,
    input  wire logic [7:0]  err_stat_i,
    input  wire logic [15:0] life_hours_i,
    // Self-test completion report
    input  wire logic        st_log_i,
    input  wire logic        st_lba28_i,
    input  wire logic [7:0]  st_num_i,
    input  wire logic [7:0]  st_status_i,
    input  wire logic [7:0]  st_chkpt_i,
    input  wire logic [47:0] st_lba_i,
    // Command completion
    output logic             busy_o,
    output logic             abort_o,
    output logic             done_o,
    output logic             intrq_o,
    // Log byte stream
    output logic [7:0]       dout_o,
    output logic             dout_valid_o,
    input  wire logic        dout_ready_i
);
    localparam int EW = ELR_ERR_ENTRY_BYTES * 8;
    localparam int SW = ELR_ST_ENTRY_BYTES * 8;
    localparam int HW = ELR_CMD_SNAPS * ELR_CMD_SNAP_BYTES * 8;
    localparam int CW = ELR_CMD_SNAP_BYTES * 8;

    // Millisecond divider is only 16 bits wide
    if (CYC_PER_MS < 1 || CYC_PER_MS > 65535) begin : g_bad_cyc
        $error("CYC_PER_MS out of range");
    end

    // Sectors in a supported log, zero if none
    function automatic logic [16:0] log_secs(input logic [7:0] a);
        if (a == ELR_LOG_DIR || a == ELR_LOG_ERR || a == ELR_LOG_ST) begin
            log_secs = ELR_SECS_ONE;
        end else if (a >= ELR_LOG_HOST_LO && a <= ELR_LOG_HOST_HI) begin
            log_secs = ELR_SECS_HOST;
        end else begin
            log_secs = 17'h00000;
        end
    endfunction

    logic [2:0]   ctrl_reg;
    elr_state_t   state_reg;
    logic [7:0]   log_reg;
    logic [15:0]  sec_left_reg;
    logic [8:0]   off_reg;
    logic [4:0]   ent_k_reg;
    logic [6:0]   ent_o_reg;
    logic [7:0]   sum_reg;
    logic [HW-1:0] hist_reg;
    logic [2:0]   state_at_cmd_reg;
    logic [31:0]  ms_reg;
    logic [15:0]  ms_div_reg;
    logic [EW-1:0] err_mem [ELR_ERR_ENTRIES];
    logic [SW-1:0] st_mem [ELR_ST_ENTRIES];
    logic [2:0]   err_idx_reg;
    logic [4:0]   st_idx_reg;
    logic [15:0]  ecnt_reg;

    // Command decode
    logic        rd_cmd;
    logic [7:0]  req_log;
    logic [15:0] req_cnt;
    logic [15:0] req_start;
    logic        feat_ok;
    logic        range_ok;
    logic        req_ok;
    logic [16:0] req_end;

    assign rd_cmd    = en_i && cmd_valid_i && cmd_code_i == ELR_CMD_READ_LOG
                       && state_reg == ELR_IDLE;
    assign req_log   = sn_cur_i;
    assign req_cnt   = {sn_prev_i, sc_cur_i};
    assign req_start = {cl_prev_i, cl_cur_i};
    assign req_end   = {1'b0, req_start} + {1'b0, req_cnt};

    // Feature-set gating of each log
    always_comb begin
        feat_ok = 1'b0;
        if (req_log == ELR_LOG_DIR) begin
            feat_ok = 1'b1;
        end else if (req_log == ELR_LOG_ERR) begin
            feat_ok = ctrl_reg[ELR_CTRL_ERRLOG];
        end else if (req_log == ELR_LOG_ST) begin
            feat_ok = ctrl_reg[ELR_CTRL_SELFTEST];
        end else if (req_log >= ELR_LOG_HOST_LO && req_log <= ELR_LOG_HOST_HI) begin
            feat_ok = ctrl_reg[ELR_CTRL_SMART];
        end
    end

    // 06h falls out through log_secs being zero
    assign range_ok = req_cnt != 16'h0000 && req_end <= log_secs(req_log);
    assign req_ok   = feat_ok && range_ok && req_log != ELR_LOG_OLD_ST;

    // Byte fetch for the current offset
    logic       load;
    logic [7:0] raw;
    logic [7:0] base;
    logic [7:0] out_byte;
    logic [16:0] dir_secs;
    logic [9:0] ebit;
    logic [7:0] sbit;
    logic [2:0] err_slot;
    logic [4:0] st_slot;

    assign load     = en_i && state_reg == ELR_XFER && (!dout_valid_o || dout_ready_i);
    assign dir_secs = log_secs(off_reg[8:1]);
    assign ebit     = {ent_o_reg, 3'b000};
    assign sbit     = {ent_o_reg[4:0], 3'b000};

    always_comb begin
        raw = 8'h00;
        unique case (log_reg)
            ELR_LOG_DIR: begin
                if (off_reg == 9'h000) begin
                    raw = ELR_DIR_VERSION;
                end else if (off_reg[8:1] != 8'h00) begin
                    raw = off_reg[0] ? dir_secs[15:8] : dir_secs[7:0];
                end
            end
            ELR_LOG_ERR: begin
                if (off_reg == 9'h000) begin
                    raw = ELR_ERR_VERSION;
                end else if (off_reg == ELR_OFF_IDX) begin
                    raw = {5'h00, err_idx_reg};
                end else if (off_reg == ELR_OFF_ECNT) begin
                    raw = ecnt_reg[7:0];
                end else if (off_reg == ELR_OFF_ECNT + 9'h001) begin
                    raw = ecnt_reg[15:8];
                end else if (off_reg >= ELR_OFF_ENTRY && off_reg < ELR_OFF_ECNT) begin
                    raw = err_mem[ent_k_reg[1:0]][ebit +: 8];
                end
            end
            ELR_LOG_ST: begin
                if (off_reg == 9'h000) begin
                    raw = ELR_ST_REVISION;
                end else if (off_reg == ELR_OFF_IDX) begin
                    raw = {3'h0, st_idx_reg};
                end else if (off_reg >= ELR_OFF_ENTRY
                             && ent_k_reg < 5'(ELR_ST_ENTRIES)) begin
                    raw = st_mem[ent_k_reg][sbit +: 8];
                end
            end
            default: raw = 8'h00;                            // Host logs read blank
        endcase
    end

    // Last byte closes the sum to zero
    assign base     = (off_reg == 9'h000) ? 8'h00 : sum_reg;
    assign out_byte = (off_reg == ELR_OFF_LAST) ? 8'h00 - base : raw;

    // Transfer sequencing
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg    <= ELR_IDLE;
            log_reg      <= 8'h00;
            sec_left_reg <= 16'h0000;
            off_reg      <= 9'h000;
            done_o       <= 1'b0;
            abort_o      <= 1'b0;
        end else if (en_i) begin
            done_o  <= 1'b0;
            abort_o <= 1'b0;
            unique case (state_reg)
                ELR_IDLE: begin
                    if (rd_cmd) begin
                        if (req_ok) begin
                            state_reg    <= ELR_XFER;
                            log_reg      <= req_log;
                            sec_left_reg <= req_cnt;
                            // Single-sector logs only accept start 0
                            off_reg      <= 9'h000;
                        end else begin
                            abort_o <= 1'b1;
                        end
                    end
                end
                ELR_XFER: begin
                    if (load) begin
                        off_reg <= off_reg + 9'h001;
                        if (off_reg == ELR_OFF_LAST) begin
                            sec_left_reg <= sec_left_reg - 16'h0001;
                            if (sec_left_reg == 16'h0001) begin
                                state_reg <= ELR_DRAIN;
                            end
                        end
                    end
                end
                ELR_DRAIN: begin
                    if (dout_ready_i) begin
                        state_reg <= ELR_IDLE;
                        done_o    <= 1'b1;
                    end
                end
                default: state_reg <= ELR_IDLE;
            endcase
        end
    end

    // Entry walk and running checksum, restarted each sector
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ent_k_reg <= 5'h00;
            ent_o_reg <= 7'h00;
            sum_reg   <= 8'h00;
        end else if (load) begin
            sum_reg <= base + raw;
            if (off_reg == 9'h000) begin
                ent_k_reg <= 5'h00;
                ent_o_reg <= 7'h00;
            end else if (off_reg >= ELR_OFF_ENTRY) begin
                if (ent_o_reg == (log_reg == ELR_LOG_ERR ? ELR_ERR_LAST_O : ELR_ST_LAST_O)) begin
                    ent_o_reg <= 7'h00;
                    ent_k_reg <= ent_k_reg + 5'h01;
                end else begin
                    ent_o_reg <= ent_o_reg + 7'h01;
                end
            end
        end
    end

    // Output byte register and per-sector interrupt
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dout_o       <= 8'h00;
            dout_valid_o <= 1'b0;
            intrq_o      <= 1'b0;
        end else if (en_i) begin
            intrq_o <= load && off_reg == 9'h000;
            if (load) begin
                dout_o       <= out_byte;
                dout_valid_o <= 1'b1;
            end else if (dout_ready_i) begin
                dout_valid_o <= 1'b0;
            end
        end
    end

    assign busy_o = state_reg != ELR_IDLE;

    // Millisecond power-on time base
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ms_div_reg <= 16'h0000;
            ms_reg     <= 32'h0000_0000;
        end else if (en_i) begin
            if (ms_div_reg == 16'(CYC_PER_MS - 1)) begin
                ms_div_reg <= 16'h0000;
                ms_reg     <= ms_reg + 32'h0000_0001;
            end else begin
                ms_div_reg <= ms_div_reg + 16'h0001;
            end
        end
    end

    // Rolling history of the last five commands, newest highest
    logic [CW-1:0] snap;
    assign snap = {ms_reg, 8'h00, cmd_code_i, devhead_i, ch_prev_i, ch_cur_i,
                   cl_prev_i, cl_cur_i, sn_prev_i, sn_cur_i, sc_prev_i, sc_cur_i,
                   feat_prev_i, feat_cur_i, devctl_i};

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hist_reg         <= '0;
            state_at_cmd_reg <= ELR_PS_UNKNOWN;
        end else if (en_i && cmd_valid_i) begin
            hist_reg         <= {snap, hist_reg[HW-1:CW]};
            state_at_cmd_reg <= pwr_state_i;
        end
    end

    // Error entry assembly and circular store
    logic [ELR_ERR_SNAP_BYTES*8-1:0] esnap;
    logic        err_take;
    assign esnap = {life_hours_i, 5'h00, state_at_cmd_reg, 152'h0, err_stat_i, err_dh_i,
                    err_ch_i, err_cl_i, err_sn_i, err_sc_i, err_code_i, 8'h00};
    assign err_take = en_i && err_log_i && err_dev_i;
    assign err_slot = (err_idx_reg == 3'(ELR_ERR_ENTRIES)) ? 3'h0 : err_idx_reg;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < ELR_ERR_ENTRIES; i++) begin
                err_mem[i] <= '0;
            end
            err_idx_reg <= 3'h0;
        end else if (err_take) begin
            err_mem[err_slot[1:0]] <= {esnap, hist_reg};
            err_idx_reg <= err_slot + 3'h1;
        end
    end

    // Device error count, saturating
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ecnt_reg <= 16'h0000;
        end else if (err_take && ecnt_reg != 16'hffff) begin
            ecnt_reg <= ecnt_reg + 16'h0001;
        end
    end

    // Self-test descriptor store; 28-bit results carry a zero-extended address
    logic [47:0] st_lba;
    assign st_lba  = st_lba28_i ? {20'h00000, st_lba_i[27:0]} : st_lba_i;
    assign st_slot = (st_idx_reg == 5'(ELR_ST_ENTRIES)) ? 5'h00 : st_idx_reg;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < ELR_ST_ENTRIES; i++) begin
                st_mem[i] <= '0;
            end
            st_idx_reg <= 5'h00;
        end else if (en_i && st_log_i) begin
            st_mem[st_slot] <= {120'h0, st_lba, st_chkpt_i, life_hours_i,
                                st_status_i, st_num_i};
            st_idx_reg <= st_slot + 5'h01;
        end
    end

    // Control and status registers
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_reg    <= ELR_CTRL_RESET;
            reg_rdata_o <= 32'h0000_0000;
        end else if (en_i) begin
            if (reg_wr_i && reg_addr_i == ELR_REG_CTRL) begin
                ctrl_reg <= reg_wdata_i[2:0];
            end
            reg_rdata_o <= 32'h0000_0000;
            if (reg_rd_i) begin
                unique case (reg_addr_i)
                    ELR_REG_CTRL: reg_rdata_o <= {29'h0, ctrl_reg};
                    ELR_REG_STAT: reg_rdata_o <= {11'h0, st_idx_reg, 5'h0, err_idx_reg,
                                                  7'h0, busy_o};
                    ELR_REG_ECNT: reg_rdata_o <= {16'h0, ecnt_reg};
                    default:      reg_rdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Checks
    sequence bad_log_s;
        rd_cmd && req_log == ELR_LOG_OLD_ST;
    endsequence

    sequence zero_cnt_s;
        rd_cmd && req_cnt == 16'h0000;
    endsequence

    abort_log06_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        bad_log_s |=> abort_o && !busy_o) else $error("log 06h not aborted");
    abort_zero_cnt_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        zero_cnt_s |=> abort_o) else $error("zero count not aborted");
    dir_version_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        load && log_reg == ELR_LOG_DIR && off_reg == 9'h000 |=> dout_o == 8'h01)
        else $error("directory version wrong");
    err_index_range_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        err_idx_reg <= 3'h4) else $error("error index above 4");
    ecnt_saturate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ecnt_reg == 16'hffff |=> ecnt_reg == 16'hffff) else $error("count wrapped");
    host_fault_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        err_log_i && !err_dev_i && !$past(err_take) |=> $stable(ecnt_reg))
        else $error("host fault counted");
    sector_irq_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        rd_cmd && req_ok |=> ##[1:2] intrq_o) else $error("no sector interrupt");
    checksum_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        load && off_reg == ELR_OFF_LAST |=> 8'(sum_reg + dout_o) == 8'h00)
        else $error("sector sum not zero");
    st_index_range_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        st_idx_reg <= 5'd18) else $error("self-test index above 18");
endmodule

// ==== elr_host.sv ====
// Host adapter model: drains the log byte stream with stalls, keeps the
// last sector, a byte sum and a byte count. Assumes dout holds while waiting.
`timescale 1ns/10ps
module elr_host (
    // Clock and control
    input  wire logic       mclk_i,
    input  wire logic       clr_i,
    input  wire logic       stall_i,
    // Byte stream from the engine
    input  wire logic [7:0] dout_i,
    input  wire logic       valid_i,
    output logic            ready_o,
    // Captured data
    output logic [7:0]      mem_o [512],
    output logic [7:0]      sum_o,
    output int              cnt_o
);
    // Stall input changes just after an edge, so ready does too
    assign ready_o = !stall_i;
    // Later sectors overwrite earlier ones; only the last stays whole
    always_ff @(posedge mclk_i) begin
        if (clr_i) begin
            sum_o <= 8'h00;
            cnt_o <= 0;
        end else if (valid_i && ready_o) begin
            mem_o[cnt_o[8:0]] <= dout_i;
            sum_o             <= sum_o + dout_i;
            cnt_o             <= cnt_o + 1;
        end
    end
endmodule

// ==== extended_log_read_engine_tb.sv ====
// Bench for the log read engine: request table, then history cases.
// Assumes elr_host.sv drains the stream.
`timescale 1ns/10ps
module extended_log_read_engine_tb;
    import elr_pkg::*;
    typedef struct packed {
        logic [7:0]  lg;
        logic [15:0] n;
        logic [15:0] s;
        logic [2:0]  c;
        logic        ab;
    } elr_row_t;
    logic        mclk_i, rstn_i, en_i, reg_wr_i, reg_rd_i, cmd_valid_i, err_log_i, err_dev_i;
    logic        st_log_i, st_lba28_i, busy_o, abort_o, done_o, intrq_o;
    logic        dout_valid_o, dout_ready_i, stall;
    logic [3:0]  reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, rv;
    logic [7:0]  cmd_code_i, devctl_i, feat_cur_i, feat_prev_i, sc_cur_i, sc_prev_i, sn_cur_i;
    logic [7:0]  sn_prev_i, cl_cur_i, cl_prev_i, ch_cur_i, ch_prev_i, devhead_i, err_code_i;
    logic [7:0]  err_dh_i, err_stat_i, st_num_i, st_status_i, st_chkpt_i, dout_o, sum;
    logic [15:0] err_sc_i, err_sn_i, err_cl_i, err_ch_i, life_hours_i;
    logic [2:0]  pwr_state_i;
    logic [47:0] st_lba_i;
    logic [7:0]  mem [512];
    int          bytes, err_total, cmp_count, cyc, iqn;
    elr_row_t    rows [13] = '{
        '{8'h00, 16'h1, 16'h0, 3'h7, 1'h0}, '{8'h03, 16'h1, 16'h0, 3'h7, 1'h0},
        '{8'h07, 16'h1, 16'h0, 3'h7, 1'h0}, '{8'h80, 16'h10, 16'h0, 3'h7, 1'h0},
        '{8'h9f, 16'h1, 16'hf, 3'h7, 1'h0}, '{8'h9f, 16'h2, 16'hf, 3'h7, 1'h1},
        '{8'h06, 16'h1, 16'h0, 3'h7, 1'h1}, '{8'ha0, 16'h1, 16'h0, 3'h7, 1'h1},
        '{8'h03, 16'h0, 16'h0, 3'h7, 1'h1}, '{8'h03, 16'h1, 16'h1, 3'h7, 1'h1},
        '{8'h03, 16'h1, 16'h0, 3'h5, 1'h1}, '{8'h07, 16'h1, 16'h0, 3'h3, 1'h1},
        '{8'h80, 16'h1, 16'h0, 3'h6, 1'h1}};

    elr_engine #(.CYC_PER_MS(4)) dut (.mclk_i, .rstn_i, .en_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .cmd_valid_i, .cmd_code_i, .devctl_i, .feat_cur_i,
        .feat_prev_i, .sc_cur_i, .sc_prev_i, .sn_cur_i, .sn_prev_i, .cl_cur_i, .cl_prev_i,
        .ch_cur_i, .ch_prev_i, .devhead_i, .pwr_state_i, .err_log_i, .err_dev_i, .err_code_i,
        .err_sc_i, .err_sn_i, .err_cl_i, .err_ch_i, .err_dh_i, .err_stat_i, .life_hours_i,
        .st_log_i, .st_lba28_i, .st_num_i, .st_status_i, .st_chkpt_i, .st_lba_i, .busy_o,
        .abort_o, .done_o, .intrq_o, .dout_o, .dout_valid_o, .dout_ready_i);
    elr_host host (.mclk_i, .clr_i(cmd_valid_i), .stall_i(stall), .dout_i(dout_o),
        .valid_i(dout_valid_o), .ready_o(dout_ready_i), .mem_o(mem), .sum_o(sum), .cnt_o(bytes));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Register strobes last one cycle; read data sampled the cycle after
    task automatic rd(input logic [3:0] a);
        @(posedge mclk_i);
        {reg_rd_i, reg_addr_i} <= {1'h1, a};
        @(posedge mclk_i);
        reg_rd_i <= 1'h0;
        #1 rv = reg_rdata_o;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'h1, a, d};
        @(posedge mclk_i);
        reg_wr_i <= 1'h0;
    endtask
    // One log read: count interrupts until abort or done
    task automatic cmd(input elr_row_t r);
        wr(ELR_REG_CTRL, {29'h0, r.c});
        @(posedge mclk_i);
        {cmd_valid_i, cmd_code_i, sn_cur_i, sc_cur_i, sn_prev_i, cl_cur_i, cl_prev_i} <=
            {1'h1, ELR_CMD_READ_LOG, r.lg, r.n[7:0], r.n[15:8], r.s[7:0], r.s[15:8]};
        {devctl_i, feat_cur_i, feat_prev_i, sc_prev_i, ch_cur_i, ch_prev_i, devhead_i} <=
            {8'h08, 8'h5a, 8'ha5, r.lg, r.lg, ~r.lg, 8'he0};
        @(posedge mclk_i);
        cmd_valid_i <= 1'h0;
        #1 chk(busy_o, !r.ab);
        iqn = 0;
        repeat (40000) begin
            @(negedge mclk_i);
            iqn += int'(intrq_o === 1'h1);
            if (abort_o === 1'h1 || done_o === 1'h1) break;
        end
        chk(abort_o, r.ab);
        chk(iqn, r.ab ? 32'h0 : {16'h0, r.n});
        chk(bytes, r.ab ? 32'h0 : {7'h0, r.n, 9'h0});
        chk(sum, 8'h00);
    endtask
    task automatic err(input logic [7:0] k, input logic d);
        @(posedge mclk_i);
        {err_log_i, err_dev_i} <= {1'h1, d};
        {err_code_i, err_sc_i, err_sn_i, err_cl_i, err_ch_i, err_dh_i, err_stat_i,
            life_hours_i} <= {k, {6{k, 8'hc3}}};
        @(posedge mclk_i);
        err_log_i <= 1'h0;
    endtask

    initial begin
        mclk_i = 1'h0;
        forever #20 mclk_i = ~mclk_i;
    end
    // Cycle count, a stall one cycle in four, and the hang limit
    always @(posedge mclk_i) begin
        cyc   <= cyc + 1;
        stall <= cyc[1] & cyc[0];
        if (cyc == 95000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        {en_i, reg_wr_i, reg_rd_i, cmd_valid_i, err_log_i, err_dev_i, st_log_i, st_lba28_i,
            stall, reg_addr_i, reg_wdata_i, cmd_code_i, devctl_i, feat_cur_i, feat_prev_i,
            sc_cur_i, sc_prev_i, sn_cur_i, sn_prev_i, cl_cur_i, cl_prev_i, ch_cur_i, ch_prev_i,
            devhead_i, err_code_i, err_dh_i, err_stat_i, st_num_i, st_status_i, st_chkpt_i,
            err_sc_i, err_sn_i, err_cl_i, err_ch_i, life_hours_i, st_lba_i, err_total,
            cmp_count, cyc, rstn_i} = '0;
        pwr_state_i = ELR_PS_ACTIVE;
        repeat (10) @(posedge mclk_i);
        {rstn_i, en_i} <= 2'h3;
        rd(ELR_REG_CTRL);
        chk(rv, 32'h7);
        rd(ELR_REG_STAT);
        chk(rv, 32'h0);
        rd(4'hc);
        chk(rv, 32'h0);
        for (int k = 0; k < 13; k++) cmd(rows[k]);
        cmd(rows[0]);
        chk({mem[1], mem[0]}, 32'h1);
        chk({mem[257], mem[256], mem[14], mem[6]}, 32'h00100101);
        cmd(rows[1]);
        chk({mem[2], mem[0], mem[95]}, 32'h000100);
        err(8'h77, 1'h0);
        for (int k = 1; k < 6; k++) err(k[7:0], 1'h1);
        rd(ELR_REG_ECNT);
        chk(rv, 32'h5);
        cmd(rows[1]);
        chk({mem[2], mem[95], mem[219], mem[500]}, 32'h01050205);
        chk({mem[97], mem[96], mem[125]}, 32'h05c303);
        chk({mem[78], mem[77], mem[88]}, 32'ha55a2f);
        @(posedge mclk_i);
        {err_log_i, err_dev_i} <= 2'h3;
        repeat (65540) @(posedge mclk_i);
        err_log_i <= 1'h0;
        rd(ELR_REG_ECNT);
        chk(rv, 32'hffff);
        for (int k = 1; k < 20; k++) begin
            @(posedge mclk_i);
            {st_log_i, st_lba28_i, st_num_i, st_status_i, st_chkpt_i, st_lba_i} <=
                {1'h1, k[0], k[7:0], 8'h11, ~k[7:0], 48'hffffffffffff};
            @(posedge mclk_i);
            st_log_i <= 1'h0;
        end
        rd(ELR_REG_STAT);
        chk(rv[20:16], 32'h1);
        cmd(rows[2]);
        chk({mem[0], mem[2], mem[4], mem[30]}, 32'h01011302);
        chk({mem[14], mem[13], mem[12], mem[38]}, 32'h00000fff);
        // Frozen engine, then a foreign code: neither may start a transfer
        @(posedge mclk_i);
        {en_i, cmd_valid_i} <= 2'h1;
        @(posedge mclk_i);
        {en_i, cmd_code_i} <= {1'h1, 8'h25};
        @(posedge mclk_i);
        cmd_valid_i <= 1'h0;
        #1 chk({busy_o, abort_o}, 2'h0);
        give_verdict();
    end
endmodule
